// [rtl/mnp_defs.svh]
// constants for the mii nibble port
`ifndef MNP_DEFS_SVH
`define MNP_DEFS_SVH
`define MNP_SYNC_STAGES 3
`define MNP_BUF_DEPTH 2
`define MNP_NIB_W 4
`define MNP_BYTE_W 8
`define MNP_CLK_SYS_MHZ 125
`define MNP_LINK_MAX_MHZ 25
`define MNP_NIB_LO 1'b0
`define MNP_NIB_HI 1'b1
`endif

// [rtl/mnp_pkg.sv]
// types for the mii nibble port
package mnp_pkg;
  typedef enum logic [1:0] {
    MNP_TX_IDLE = 2'b00,
    MNP_TX_LO = 2'b01,
    MNP_TX_HI = 2'b11
  } mnp_tx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mnp_tx_word_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic err;
  } mnp_rx_word_t;
endpackage

// [rtl/mnp_buf2.sv]
// two-entry valid/ready buffer
`timescale 1ns/10ps
module mnp_buf2 #(
  parameter int W = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_r [0:1];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // mnp_buf2

// [rtl/mnp_port.sv]
// mii nibble port: transmit and receive pin logic on the system clock
`timescale 1ns/10ps
`include "mnp_defs.svh"
module mnp_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic serial_encoder_mode,
  input wire logic tx_clk,
  output logic tx_en,
  output logic [3:0] txd,
  input wire logic rx_clk,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic [3:0] rxd,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_busy,
  output logic tx_underrun,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic rx_err,
  output logic rx_overflow
);
  // three-stage samplers for link clocks and receive pins
  logic [2:0] txc_s_r;
  logic [2:0] rxc_s_r;
  logic [2:0] dv_s_r;
  logic [2:0] er_s_r;
  logic [3:0] rxd_s1_r;
  logic [3:0] rxd_s2_r;
  logic [3:0] rxd_s3_r;
  logic txc_lvl_r;
  logic rxc_lvl_r;
  logic tx_rise;
  logic rx_rise;

  // a level counts once the second and third stages agree
  function automatic logic agreed(input logic s2, input logic s3, input logic prev);
    agreed = (s2 == s3) ? s2 : prev;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txc_s_r <= 3'h0;
      rxc_s_r <= 3'h0;
      dv_s_r <= 3'h0;
      er_s_r <= 3'h0;
      rxd_s1_r <= 4'h0;
      rxd_s2_r <= 4'h0;
      rxd_s3_r <= 4'h0;
    end else begin
      txc_s_r <= {txc_s_r[1:0], tx_clk};
      rxc_s_r <= {rxc_s_r[1:0], rx_clk};
      dv_s_r <= {dv_s_r[1:0], rx_dv};
      er_s_r <= {er_s_r[1:0], rx_er};
      rxd_s1_r <= rxd;
      rxd_s2_r <= rxd_s1_r;
      rxd_s3_r <= rxd_s2_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txc_lvl_r <= 1'b0;
      rxc_lvl_r <= 1'b0;
    end else begin
      txc_lvl_r <= agreed(txc_s_r[1], txc_s_r[2], txc_lvl_r);
      rxc_lvl_r <= agreed(rxc_s_r[1], rxc_s_r[2], rxc_lvl_r);
    end
  end

  assign tx_rise = agreed(txc_s_r[1], txc_s_r[2], txc_lvl_r) && !txc_lvl_r;
  assign rx_rise = agreed(rxc_s_r[1], rxc_s_r[2], rxc_lvl_r) && !rxc_lvl_r;

  // transmit
  logic [9:0] tbuf_in;
  logic [9:0] tbuf_out;
  logic tbuf_valid;
  logic tbuf_pop;
  mnp_pkg::mnp_tx_word_t tw;
  mnp_pkg::mnp_tx_state_t tx_st_r;
  logic [7:0] tsh_r;
  logic tlast_r;
  logic [2:0] tcnt_r;
  logic tx_en_r;
  logic [3:0] txd_r;
  logic under_r;

  assign tbuf_in = {tx_data, tx_last, 1'b0};
  assign tw = mnp_pkg::mnp_tx_word_t'(tbuf_out[9:1]);

  mnp_buf2 #(.W(10)) u_tbuf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tbuf_in),
    .out_valid(tbuf_valid),
    .out_ready(tbuf_pop),
    .out_data(tbuf_out)
  );

  // byte taken when the last piece of the current one goes out
  logic tx_need;
  assign tx_need = (tx_st_r == mnp_pkg::MNP_TX_IDLE) ||
    (serial_encoder_mode ? (tcnt_r == 3'd7) : (tx_st_r == mnp_pkg::MNP_TX_HI));
  assign tbuf_pop = tx_rise && tx_need && tbuf_valid &&
    !((tx_st_r != mnp_pkg::MNP_TX_IDLE) && tlast_r);

  // the pins change only on a seen transmit clock rise; the phy samples on
  // the next rise, so our few-cycle sampler lag stays well inside one period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_st_r <= mnp_pkg::MNP_TX_IDLE;
      tsh_r <= 8'h00;
      tlast_r <= 1'b0;
      tcnt_r <= 3'd0;
      tx_en_r <= 1'b0;
      txd_r <= 4'h0;
      under_r <= 1'b0;
    end else if (tx_rise) begin
      under_r <= 1'b0;
      if (tbuf_pop) begin
        // enable rises with the first nibble
        tx_en_r <= 1'b1;
        tsh_r <= tw.data;
        tlast_r <= tw.last;
        tcnt_r <= 3'd0;
        txd_r <= serial_encoder_mode ? {3'h0, tw.data[0]} : tw.data[3:0];
        tx_st_r <= mnp_pkg::MNP_TX_LO;
      end else if (tx_st_r != mnp_pkg::MNP_TX_IDLE && !tx_need) begin
        // next piece of the current byte
        if (serial_encoder_mode) begin
          // one bit per clock on bit 0
          txd_r <= {3'h0, tsh_r[tcnt_r + 3'd1]};
          tcnt_r <= tcnt_r + 3'd1;
        end else begin
          txd_r <= tsh_r[7:4];
          tx_st_r <= mnp_pkg::MNP_TX_HI;
        end
      end else begin
        // enable drops on the edge after the final nibble
        under_r <= (tx_st_r != mnp_pkg::MNP_TX_IDLE) && !tlast_r;
        tx_en_r <= 1'b0;
        txd_r <= 4'h0;
        tx_st_r <= mnp_pkg::MNP_TX_IDLE;
      end
    end
  end

  // active-high enable straight from a flop
  assign tx_en = tx_en_r;
  assign txd = txd_r;
  assign tx_busy = tx_en_r;
  assign tx_underrun = under_r && tx_rise;

  // receive
  logic dv_lvl;
  logic er_lvl;
  logic dv_prev_r;
  logic [7:0] rsh_r;
  logic [2:0] rcnt_r;
  logic rerr_r;
  logic rpend_r;
  logic [7:0] rpend_data_r;
  logic rpend_err_r;
  logic rb_valid;
  logic rb_ready;
  logic [9:0] rb_in;
  logic [9:0] rb_out;
  mnp_pkg::mnp_rx_word_t rw;
  logic ovf_r;

  // the receive pins settle long before the clock rise is seen
  assign dv_lvl = dv_s_r[2];
  assign er_lvl = er_s_r[2];

  // a finished byte waits one clock so the frame end can mark it last
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dv_prev_r <= 1'b0;
      rsh_r <= 8'h00;
      rcnt_r <= 3'd0;
      rerr_r <= 1'b0;
      rpend_r <= 1'b0;
      rpend_data_r <= 8'h00;
      rpend_err_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      ovf_r <= 1'b0;
      if (rb_valid && !rb_ready) begin
        ovf_r <= 1'b1;
      end
      if (rx_rise) begin
        dv_prev_r <= dv_lvl;
        if (rb_valid) begin
          rpend_r <= 1'b0;
        end
        // pins discarded while valid is low
        if (dv_lvl) begin
          // error counts only with valid high
          rerr_r <= (dv_prev_r ? rerr_r : 1'b0) | er_lvl;
          if (serial_encoder_mode) begin
            // one bit per clock from bit 0, lsb first
            rsh_r <= {rxd_s3_r[0], rsh_r[7:1]};
            rcnt_r <= dv_prev_r ? rcnt_r + 3'd1 : 3'd1;
            if (rcnt_r == 3'd7 && dv_prev_r) begin
              rpend_r <= 1'b1;
              rpend_data_r <= {rxd_s3_r[0], rsh_r[7:1]};
              rpend_err_r <= rerr_r | er_lvl;
              rerr_r <= 1'b0;
              rcnt_r <= 3'd0;
            end
          end else begin
            rsh_r <= {rxd_s3_r, rsh_r[7:4]};
            // a frame's first nibble always opens a byte
            rcnt_r <= (!dv_prev_r || rcnt_r == 3'd0) ? 3'd1 : 3'd0;
            if (dv_prev_r && rcnt_r == 3'd1) begin
              rpend_r <= 1'b1;
              rpend_data_r <= {rxd_s3_r, rsh_r[7:4]};
              rpend_err_r <= rerr_r | er_lvl;
              rerr_r <= 1'b0;
            end
          end
        end
      end
    end
  end

  // byte released at the next rise; last when valid has fallen
  assign rb_valid = rx_rise && rpend_r;
  assign rb_in = {rpend_data_r, !dv_lvl, rpend_err_r};

  mnp_buf2 #(.W(10)) u_rbuf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(rb_valid),
    .in_ready(rb_ready),
    .in_data(rb_in),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rb_out)
  );

  assign rw = mnp_pkg::mnp_rx_word_t'(rb_out);
  assign rx_data = rw.data;
  assign rx_last = rw.last;
  assign rx_err = rw.err;
  // a stall past two bytes cannot hold back the phy
  assign rx_overflow = ovf_r;
endmodule // mnp_port

// [verif/mnp_port_properties.sv]
// pin and receive-stream checks for the mii nibble port
`timescale 1ns/10ps
module mnp_port_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic serial_encoder_mode,
  input wire logic tx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic tx_busy,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_err,
  input wire logic rx_overflow
);
  logic tx_clk_q;
  logic [3:0] since_rise_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // edges since tx clock rose; saturates so idle time never wraps
  always_ff @(posedge clk_sys) begin
    tx_clk_q <= tx_clk;
    if (rst) begin
      since_rise_r <= 4'hf;
    end else if (tx_clk && !tx_clk_q) begin
      since_rise_r <= 4'h0;
    end else if (since_rise_r != 4'hf) begin
      since_rise_r <= since_rise_r + 4'h1;
    end
  end
  busy_is_en_a: assert property (tx_busy == tx_en)
    else $error("busy differs from enable");
  en_clk_step_a: assert property ($changed(tx_en) |-> since_rise_r <= 4'h6)
    else $error("enable moved off the tx clock");
  txd_clk_step_a: assert property ($changed(txd) |-> since_rise_r <= 4'h6)
    else $error("data moved off the tx clock");
  serial_bit0_a: assert property (serial_encoder_mode && tx_en |-> txd[3:1] == 3'h0)
    else $error("serial mode used upper bits");
  en_stands_a: assert property ($rose(tx_en) |=> tx_en [*8])
    else $error("enable dropped inside a period");
  txd_stands_a: assert property ($changed(txd) |=> $stable(txd) [*8])
    else $error("data changed inside a period");
  rx_word_hold_a: assert property (rx_valid && !rx_ready |=>
    rx_valid && $stable(rx_data) && $stable(rx_last) && $stable(rx_err))
    else $error("stalled byte not held");
  ovf_when_full_a: assert property (rx_overflow |-> rx_valid)
    else $error("overflow with empty buffer");
  cover property ($rose(tx_en) && serial_encoder_mode);
  cover property (rx_overflow);
  cover property (rx_valid && rx_ready && rx_last && rx_err);
endmodule // mnp_port_properties

bind mnp_port mnp_port_properties chk_u (.clk_sys, .rst, .serial_encoder_mode, .tx_clk,
  .tx_en, .txd, .tx_busy, .rx_valid, .rx_ready, .rx_data, .rx_last, .rx_err, .rx_overflow);

// [verif/mnp_phy_model.sv]
// behavioural phy on the far side of the port
`timescale 1ns/10ps
module mnp_phy_model (
  output logic tx_clk,
  output logic rx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic serial_encoder_mode,
  output logic rx_dv,
  output logic rx_er,
  output logic [3:0] rxd
);
  logic [3:0] tx_q[$];
  logic [4:0] rx_q[$];
  logic en_q = 1'b0;
  int tx_frames = 0;
  // free-running clocks, slow here to give the synchronisers margin
  initial begin
    tx_clk = 1'b0;
    forever #62.5 tx_clk = ~tx_clk;
  end
  initial begin
    rx_clk = 1'b0;
    #17;
    forever #62.5 rx_clk = ~rx_clk;
  end
  always @(posedge tx_clk) begin
    if (tx_en === 1'b1) tx_q.push_back(txd);
    if (en_q && tx_en !== 1'b1) tx_frames++;
    en_q = tx_en;
  end
  initial {rx_dv, rx_er, rxd} = 6'h00;
  always @(negedge rx_clk) begin
    if (rx_q.size() != 0) begin
      {rx_er, rxd} <= rx_q.pop_front();
      rx_dv <= 1'b1;
    end else begin
      rx_dv <= 1'b0;
      rxd <= ~rxd;
      // error kept low in serial mode
      rx_er <= serial_encoder_mode ? 1'b0 : ~rx_er;
    end
  end
endmodule // mnp_phy_model

// [verif/mnp_port_bench.sv]
// self-checking bench for the mii nibble port
`timescale 1ns/10ps
module mnp_port_bench;
  logic clk_sys, rst, mode, tx_valid, tx_last, rx_ready, full_seen, ovf_seen, under_seen;
  logic tx_clk, rx_clk, tx_en, rx_dv, rx_er, tx_ready, tx_busy, tx_underrun;
  logic rx_valid, rx_last, rx_err, rx_overflow;
  logic [3:0] txd, rxd;
  logic [7:0] tx_data, rx_data;
  int mismatches, checks_done;
  mnp_port dut_u (.clk_sys, .rst, .serial_encoder_mode(mode), .tx_clk, .tx_en, .txd, .rx_clk,
    .rx_dv, .rx_er, .rxd, .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_busy, .tx_underrun,
    .rx_valid, .rx_ready, .rx_data, .rx_last, .rx_err, .rx_overflow);
  mnp_phy_model phy_u (.tx_clk, .rx_clk, .tx_en, .txd, .serial_encoder_mode(mode), .rx_dv,
    .rx_er, .rxd);
  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // holds valid across bytes so it is never lowered and raised in one step
  task automatic send_tx(input logic [7:0] b[$], input int frames, input logic ends);
    int n;
    @(posedge clk_sys);
    tx_valid <= 1'b1;
    foreach (b[i]) begin
      tx_data <= b[i];
      tx_last <= ends && (i == b.size() - 1);
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (tx_ready !== 1'b1 && n < 3000);
      check(n < 3000, "tx byte never taken");
      if (n > 1) full_seen = 1'b1;
      @(posedge clk_sys);
    end
    tx_valid <= 1'b0;
    n = 0;
    while (phy_u.tx_frames < frames && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    check(n < 5000, "frame never ended");
  endtask
  task automatic rx_send(input logic [7:0] b[$], input logic ser, input int err_at);
    for (int i = 0; i < b.size() * (ser ? 8 : 2); i++) begin
      if (ser) phy_u.rx_q.push_back({1'b0, 3'h5, b[i/8][i%8]});
      else phy_u.rx_q.push_back({i == err_at, i[0] ? b[i/2][7:4] : b[i/2][3:0]});
    end
  endtask
  task automatic rx_take(input logic [7:0] d, input logic last, input logic err);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (rx_valid !== 1'b1 && n < 2000);
    check(rx_valid === 1'b1 && rx_data === d && rx_last === last && rx_err === err, "received byte");
    @(posedge clk_sys);
    rx_ready <= 1'b1;
    @(posedge clk_sys);
    rx_ready <= 1'b0;
  endtask
  task automatic tx_nibble;
    logic [7:0] b[$];
    b = '{8'h55, 8'hd5, 8'h3c, 8'hc1, 8'h96};
    full_seen = 1'b0;
    send_tx(b, 1, 1'b1);
    check(full_seen === 1'b1, "tx buffer never refused");
    check(phy_u.tx_q.size() == 10, "nibble count");
    foreach (b[i]) begin
      check(phy_u.tx_q[2*i] === b[i][3:0] && phy_u.tx_q[2*i+1] === b[i][7:4], "nibble");
    end
  endtask
  // bytes that run out before one marked last must flag an underrun
  task automatic tx_dry;
    repeat (40) @(posedge clk_sys);
    check(under_seen === 1'b0, "underrun on a whole frame");
    send_tx('{8'h3c}, 2, 1'b0);
    repeat (40) @(posedge clk_sys);
    check(under_seen === 1'b1, "dry frame not flagged");
  endtask
  task automatic tx_serial;
    logic [7:0] sb;
    sb = 8'ha5;
    phy_u.tx_q.delete();
    mode <= 1'b1;
    send_tx('{8'ha5}, 3, 1'b1);
    check(phy_u.tx_q.size() == 8, "serial bit count");
    for (int i = 0; i < 8; i++) begin
      check(phy_u.tx_q[i] === {3'h0, sb[i]}, "serial bit");
    end
  endtask
  task automatic rx_tests;
    mode <= 1'b0;
    rx_send('{8'h12, 8'hb4}, 1'b0, 3);
    repeat (200) @(posedge clk_sys);
    rx_take(8'h12, 1'b0, 1'b0);
    rx_take(8'hb4, 1'b1, 1'b1);
    repeat (100) @(posedge clk_sys);
    check(rx_valid === 1'b0, "byte from idle lines");
    mode <= 1'b1;
    rx_send('{8'ha5}, 1'b1, 0);
    repeat (300) @(posedge clk_sys);
    rx_take(8'ha5, 1'b1, 1'b0);
    mode <= 1'b0;
    ovf_seen = 1'b0;
    rx_send('{8'h21, 8'h43, 8'h65, 8'h87, 8'ha9}, 1'b0, 99);
    repeat (300) @(posedge clk_sys);
    check(ovf_seen === 1'b1, "lost byte not flagged");
    rx_take(8'h21, 1'b0, 1'b0);
  endtask
  always @(posedge clk_sys) if (rx_overflow === 1'b1) ovf_seen <= 1'b1;
  always @(posedge clk_sys) if (tx_underrun === 1'b1) under_seen <= 1'b1;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, mode, tx_valid, tx_last, rx_ready, tx_data} = {5'h10, 8'h00};
    mismatches = 0;
    checks_done = 0;
    under_seen = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    tx_nibble();
    tx_dry();
    tx_serial();
    rx_tests();
    print_verdict();
  end
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
endmodule // mnp_port_bench
